// >>> rtl/mie_pkg.sv
package mie_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SKIP_BASE_MS = 1280;
  localparam int PROOF_BASE_MS = 240;
  localparam logic [10:0] SKIP_BASE_TICKS = 11'(SKIP_BASE_MS / TICK_MS);
  localparam logic [10:0] PROOF_BASE_TICKS = 11'(PROOF_BASE_MS / TICK_MS);
  localparam int NSRC = 13;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] A_OUT_CTRL = 8'h53;
  localparam logic [7:0] A_LATCH = 8'h54;
  localparam logic [7:0] A_MOT0 = 8'h5F;
  localparam logic [7:0] A_MOT1 = 8'h60;
  localparam logic [7:0] A_MOT2 = 8'h61;
  localparam logic [7:0] A_MOT3 = 8'h62;
  localparam logic [7:0] A_STEP0 = 8'h7A;
  localparam logic [7:0] A_STEP1 = 8'h7B;
  localparam int OC_LVL = 1;
  localparam int OC_OD = 2;
  localparam int OC_OE = 3;
  localparam int OC_STRIDE = 4;
  localparam int LT_IE = 4;
  localparam int LT_PEND = 6;
  localparam int LT_CLR = 7;
  localparam int MD_SKIP = 2;
  localparam int MD_PROOF = 4;
  localparam int MD_SEL = 25;
  localparam int ST_PRESET = 12;
  localparam logic [7:0] OUT_CTRL_RST = 8'h00;
  localparam logic [5:0] LATCH_RST = 6'h00;
  localparam logic [31:0] MOT_RST = 32'h0014_1424;
  localparam logic [15:0] STEP_RST = 16'h0000;

  // ----------------------------------------
  // sources, samples, presets
  // ----------------------------------------
  localparam int S_ANYM = 0;
  localparam int S_SIGM = 1;
  localparam int S_STEP = 2;
  localparam int S_EXT = 3;
  localparam int S_DRDY = 10;
  localparam int S_FULL = 11;
  localparam int S_WM = 12;
  localparam logic signed [15:0] SAT_NEG = 16'sh8000;
  localparam logic signed [15:0] SAT_POS = 16'sh7FFF;
  localparam logic [16:0] SLOPE_MAX = 17'h1FFFF;
  localparam logic [7:0] PK_NORMAL = 8'h40;
  localparam logic [7:0] PK_SENS = 8'h28;
  localparam logic [7:0] PK_ROBUST = 8'h60;
  localparam logic [3:0] MT_NORMAL = 4'h3;
  localparam logic [3:0] MT_SENS = 4'h2;
  localparam logic [3:0] MT_ROBUST = 4'h5;

  typedef enum logic [1:0] {SM_WAIT = 2'b00, SM_SKIP = 2'b01, SM_PROOF = 2'b10} mie_sm_t;
  typedef enum logic [1:0] {
    PR_NORMAL = 2'b00, PR_SENS = 2'b01, PR_ROBUST = 2'b10, PR_CUSTOM = 2'b11
  } mie_preset_t;

  function automatic logic [10:0] skip_ticks(input logic [1:0] code);
    return SKIP_BASE_TICKS << code;
  endfunction

  function automatic logic [10:0] proof_ticks(input logic [1:0] code);
    return PROOF_BASE_TICKS << code;
  endfunction
endpackage

// >>> rtl/mie_slope.sv
`timescale 1ns/1ps
module mie_slope (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic smp_vld,
  input wire logic signed [15:0] acc_x,
  input wire logic signed [15:0] acc_y,
  input wire logic signed [15:0] acc_z,
  input wire logic [7:0] thr,
  input wire logic [1:0] dur,
  input wire logic hold,
  output logic hit,
  output logic motion,
  output logic [2:0] first_axis,
  output logic sign
);
  logic signed [15:0] cur [3];
  logic signed [15:0] prev [3];
  logic have_prev;
  logic [2:0] above;
  logic [2:0] neg;
  logic [2:0] low1;
  logic [1:0] cnt_hi;
  logic [1:0] cnt_lo;
  logic step_ok;

  function automatic logic [16:0] slope(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [16:0] d;
    d = {a[15], a} - {b[15], b};
    if (a == mie_pkg::SAT_NEG || a == mie_pkg::SAT_POS ||
        b == mie_pkg::SAT_NEG || b == mie_pkg::SAT_POS) begin
      return mie_pkg::SLOPE_MAX;
    end
    return d[16] ? 17'(-d) : 17'(d);
  endfunction

  assign cur[0] = acc_x;
  assign cur[1] = acc_y;
  assign cur[2] = acc_z;
  assign step_ok = smp_vld && have_prev;
  assign low1 = above & ~(above - 3'h1);

  for (genvar i = 0; i < 3; i++) begin : g_ax
    assign above[i] = slope(cur[i], prev[i]) > {5'h00, thr, 4'h0};
    assign neg[i] = cur[i] < prev[i];
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        prev[i] <= 16'sh0000;
      end else if (smp_vld) begin
        prev[i] <= cur[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      have_prev <= 1'b0;
      hit <= 1'b0;
    end else begin
      have_prev <= have_prev | smp_vld;
      hit <= step_ok && |above;
    end
  end

  // counters freeze under hold so the blocked interrupt keeps its axis and sign
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_hi <= 2'h0;
      cnt_lo <= 2'h0;
      motion <= 1'b0;
      first_axis <= 3'h0;
      sign <= 1'b0;
    end else if (step_ok && !hold) begin
      if (|above) begin
        cnt_lo <= 2'h0;
        if (cnt_hi == dur) begin
          motion <= 1'b1;
          if (!motion) begin
            first_axis <= low1;
            sign <= |(low1 & neg);
          end
        end else begin
          cnt_hi <= cnt_hi + 2'h1;
        end
      end else begin
        cnt_hi <= 2'h0;
        if (cnt_lo == dur) begin
          motion <= 1'b0;
        end else begin
          cnt_lo <= cnt_lo + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  slope_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
    step_ok && !hold && |above && cnt_hi == dur |=> motion)
    else $error("slope interrupt did not rise");
  slope_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
    step_ok && !hold && above == 3'h0 && cnt_lo == dur |=> !motion)
    else $error("slope interrupt did not fall");
  slope_sat_a: assert property (@(posedge clk) disable iff (!rst_b)
    have_prev && acc_x == mie_pkg::SAT_POS |-> above[0])
    else $error("saturated sample not maximal");
  slope_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    hold |=> $stable(motion) && $stable(first_axis) && $stable(sign))
    else $error("blocked interrupt changed");
  slope_axis_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(motion) |-> $onehot(first_axis))
    else $error("first axis not recorded");
endmodule

// >>> rtl/mie_step.sv
`timescale 1ns/1ps
module mie_step (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic smp_vld,
  input wire logic tick,
  input wire logic signed [15:0] acc_x,
  input wire logic signed [15:0] acc_y,
  input wire logic signed [15:0] acc_z,
  input wire logic [7:0] peak_thr,
  input wire logic [3:0] min_t,
  output logic step
);
  logic [17:0] mag;
  logic [17:0] m1;
  logic [17:0] m2;
  logic [1:0] fill;
  logic [4:0] gap;
  logic peak;

  function automatic logic [17:0] mag1(input logic signed [15:0] a);
    // zero-extend so the most negative code reads as 32768, not as a negative sum
    return a[15] ? {2'b00, 16'(-a)} : {2'b00, a};
  endfunction

  // sum of magnitudes stands in for the vector length: no multiplier or root
  assign mag = mag1(acc_x) + mag1(acc_y) + mag1(acc_z);
  assign peak = fill == 2'h2 && m1 > m2 && m1 >= mag &&
                m1 > {2'h0, peak_thr, 8'h00} && gap >= {1'b0, min_t};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      m1 <= 18'h00000;
      m2 <= 18'h00000;
      fill <= 2'h0;
    end else if (smp_vld) begin
      m1 <= mag;
      m2 <= m1;
      fill <= (fill == 2'h2) ? fill : fill + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gap <= 5'h1F;
      step <= 1'b0;
    end else begin
      step <= smp_vld && peak;
      if (smp_vld && peak) begin
        gap <= 5'h00;
      end else if (tick && gap != 5'h1F) begin
        gap <= gap + 5'h01;
      end
    end
  end

  step_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
    step |-> gap == 5'h00 && $past(gap) >= {1'b0, $past(min_t)})
    else $error("step closer than minimum time");
  step_seen_c: cover property (@(posedge clk) disable iff (!rst_b) step);
endmodule

// >>> rtl/mie_top.sv
`timescale 1ns/1ps
module mie_top #(
  parameter int TICK_CYCLES = mie_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic suspend,
  input wire logic smp_vld,
  input wire logic signed [15:0] acc_x,
  input wire logic signed [15:0] acc_y,
  input wire logic signed [15:0] acc_z,
  input wire logic drdy_evt,
  input wire logic full_evt,
  input wire logic wm_evt,
  input wire logic [6:0] ext_evt,
  input wire logic [12:0] map1,
  input wire logic [12:0] map2,
  input wire logic int1_i,
  output logic int1_o,
  output logic int1_oe_b,
  input wire logic int2_i,
  output logic int2_o,
  output logic int2_oe_b,
  output logic trig1,
  output logic trig2,
  output logic [12:0] status,
  output logic [2:0] anym_axis,
  output logic anym_sign,
  output logic step_trig
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] out_ctrl;
  logic [5:0] latch_ctrl;
  logic [31:0] mot;
  logic [15:0] stepc;
  logic latch_on;
  logic latch_clr;
  logic sel_sig;

  assign latch_on = |latch_ctrl[3:0];
  assign sel_sig = mot[mie_pkg::MD_SEL];
  assign latch_clr = reg_wr && reg_addr == mie_pkg::A_LATCH && reg_wdata[mie_pkg::LT_CLR];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_ctrl <= mie_pkg::OUT_CTRL_RST;
      latch_ctrl <= mie_pkg::LATCH_RST;
      mot <= mie_pkg::MOT_RST;
      stepc <= mie_pkg::STEP_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        mie_pkg::A_OUT_CTRL: out_ctrl <= reg_wdata;
        mie_pkg::A_LATCH: latch_ctrl <= reg_wdata[5:0];
        mie_pkg::A_MOT0: mot[7:0] <= reg_wdata;
        mie_pkg::A_MOT1: mot[15:8] <= reg_wdata;
        mie_pkg::A_MOT2: mot[23:16] <= reg_wdata;
        mie_pkg::A_MOT3: mot[31:24] <= reg_wdata;
        mie_pkg::A_STEP0: stepc[7:0] <= reg_wdata;
        mie_pkg::A_STEP1: stepc[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // clear bit reads zero; pending shows any live flag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        mie_pkg::A_OUT_CTRL: reg_rdata <= out_ctrl;
        mie_pkg::A_LATCH: reg_rdata <= {1'b0, |status, latch_ctrl};
        mie_pkg::A_MOT0: reg_rdata <= mot[7:0];
        mie_pkg::A_MOT1: reg_rdata <= mot[15:8];
        mie_pkg::A_MOT2: reg_rdata <= mot[23:16];
        mie_pkg::A_MOT3: reg_rdata <= mot[31:24];
        mie_pkg::A_STEP0: reg_rdata <= stepc[7:0];
        mie_pkg::A_STEP1: reg_rdata <= stepc[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // time base
  // ----------------------------------------
  logic [18:0] tick_cnt;
  logic tick;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt <= 19'h00000;
      tick <= 1'b0;
    end else if (tick_cnt == 19'(TICK_CYCLES - 1)) begin
      tick_cnt <= 19'h00000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 19'h00001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // detectors
  // ----------------------------------------
  logic anym_motion;
  logic sig_hit;
  logic step_pulse;
  logic [7:0] peak_thr;
  logic [3:0] min_t;
  mie_pkg::mie_preset_t preset;

  mie_slope u_anym (
    .clk(clk),
    .rst_b(rst_b),
    .smp_vld(smp_vld),
    .acc_x(acc_x),
    .acc_y(acc_y),
    .acc_z(acc_z),
    .thr(mot[15:8]),
    .dur(mot[1:0]),
    .hold(latch_on && status[mie_pkg::S_ANYM]),
    .hit(),
    .motion(anym_motion),
    .first_axis(anym_axis),
    .sign(anym_sign)
  );

  mie_slope u_sigm (
    .clk(clk),
    .rst_b(rst_b),
    .smp_vld(smp_vld),
    .acc_x(acc_x),
    .acc_y(acc_y),
    .acc_z(acc_z),
    .thr(mot[23:16]),
    .dur(2'h0),
    .hold(1'b0),
    .hit(sig_hit),
    .motion(),
    .first_axis(),
    .sign()
  );

  assign preset = mie_pkg::mie_preset_t'(stepc[mie_pkg::ST_PRESET +: 2]);

  always_comb begin
    unique case (preset)
      mie_pkg::PR_NORMAL: begin
        peak_thr = mie_pkg::PK_NORMAL;
        min_t = mie_pkg::MT_NORMAL;
      end
      mie_pkg::PR_SENS: begin
        peak_thr = mie_pkg::PK_SENS;
        min_t = mie_pkg::MT_SENS;
      end
      mie_pkg::PR_ROBUST: begin
        peak_thr = mie_pkg::PK_ROBUST;
        min_t = mie_pkg::MT_ROBUST;
      end
      mie_pkg::PR_CUSTOM: begin
        peak_thr = stepc[7:0];
        min_t = stepc[11:8];
      end
    endcase
  end

  mie_step u_step (
    .clk(clk),
    .rst_b(rst_b),
    .smp_vld(smp_vld),
    .tick(tick),
    .acc_x(acc_x),
    .acc_y(acc_y),
    .acc_z(acc_z),
    .peak_thr(peak_thr),
    .min_t(min_t),
    .step(step_pulse)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      step_trig <= 1'b0;
    end else begin
      step_trig <= step_pulse;
    end
  end

  // ----------------------------------------
  // significant motion
  // ----------------------------------------
  mie_pkg::mie_sm_t sm_state;
  logic [10:0] sm_cnt;
  logic sig_pulse;

  // timing granularity is one tick, so the skip wait may run short by under a tick; the proof wait starts on a tick
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sm_state <= mie_pkg::SM_WAIT;
      sm_cnt <= 11'h000;
      sig_pulse <= 1'b0;
    end else begin
      sig_pulse <= 1'b0;
      if (!sel_sig) begin
        sm_state <= mie_pkg::SM_WAIT;
      end else begin
        unique case (sm_state)
          mie_pkg::SM_WAIT: begin
            if (sig_hit) begin
              sm_state <= mie_pkg::SM_SKIP;
              sm_cnt <= mie_pkg::skip_ticks(mot[mie_pkg::MD_SKIP +: 2]);
            end
          end
          mie_pkg::SM_SKIP: begin
            if (tick && sm_cnt == 11'h001) begin
              sm_state <= mie_pkg::SM_PROOF;
              sm_cnt <= mie_pkg::proof_ticks(mot[mie_pkg::MD_PROOF +: 2]);
            end else if (tick) begin
              sm_cnt <= sm_cnt - 11'h001;
            end
          end
          mie_pkg::SM_PROOF: begin
            if (sig_hit) begin
              sig_pulse <= 1'b1;
              sm_state <= mie_pkg::SM_WAIT;
            end else if (tick && sm_cnt == 11'h001) begin
              sm_state <= mie_pkg::SM_WAIT;
            end else if (tick) begin
              sm_cnt <= sm_cnt - 11'h001;
            end
          end
          default: sm_state <= mie_pkg::SM_WAIT;
        endcase
      end
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  logic [12:0] src;

  always_comb begin
    src = 13'h0000;
    src[mie_pkg::S_ANYM] = !sel_sig && anym_motion;
    src[mie_pkg::S_SIGM] = sel_sig && sig_pulse;
    src[mie_pkg::S_STEP] = step_pulse;
    src[mie_pkg::S_EXT +: 7] = ext_evt;
    src[mie_pkg::S_DRDY] = drdy_evt;
    src[mie_pkg::S_FULL] = full_evt;
    src[mie_pkg::S_WM] = wm_evt;
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status <= 13'h0000;
    end else if (latch_on) begin
      status <= (status & ~{mie_pkg::NSRC{latch_clr}}) | (suspend ? 13'h0000 : src);
    end else begin
      status <= suspend ? 13'h0000 : src;
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  logic [12:0] pin_map [2];
  logic pin_in [2];
  logic s1 [2];
  logic s2 [2];
  logic po [2];
  logic poe_b [2];
  logic tr [2];

  assign pin_map[0] = map1;
  assign pin_map[1] = map2;
  assign pin_in[0] = int1_i;
  assign pin_in[1] = int2_i;

  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic raw;
    logic lvl;
    logic od;
    logic oe;
    logic ie;
    logic val;
    assign raw = |(status & pin_map[p]);
    assign lvl = out_ctrl[p * mie_pkg::OC_STRIDE + mie_pkg::OC_LVL];
    assign od = out_ctrl[p * mie_pkg::OC_STRIDE + mie_pkg::OC_OD];
    assign oe = out_ctrl[p * mie_pkg::OC_STRIDE + mie_pkg::OC_OE];
    assign ie = latch_ctrl[mie_pkg::LT_IE + p];
    assign val = raw ~^ lvl;

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        s1[p] <= 1'b0;
        s2[p] <= 1'b0;
      end else begin
        s1[p] <= pin_in[p];
        s2[p] <= s1[p];
      end
    end

    // open drain only pulls low, otherwise the pin floats to its pull-up
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        po[p] <= 1'b0;
        poe_b[p] <= 1'b1;
        tr[p] <= 1'b0;
      end else begin
        po[p] <= od ? 1'b0 : val;
        poe_b[p] <= !(oe && (!od || !val));
        tr[p] <= ie && (oe ? val : s2[p]);
      end
    end
  end

  assign int1_o = po[0];
  assign int2_o = po[1];
  assign int1_oe_b = poe_b[0];
  assign int2_oe_b = poe_b[1];
  assign trig1 = tr[0];
  assign trig2 = tr[1];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  susp_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    !latch_on && suspend |=> status == 13'h0000)
    else $error("flag set in suspend");
  latch_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    latch_on && suspend && !latch_clr |=> status == $past(status))
    else $error("latched flags changed in suspend");
  set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
    latch_on && latch_clr && !suspend && drdy_evt |=> status == 13'h0001 << mie_pkg::S_DRDY ||
    status[mie_pkg::S_DRDY])
    else $error("event lost against clear");
  drdy_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    !suspend && !latch_on && drdy_evt |=> status[mie_pkg::S_DRDY])
    else $error("data ready flag missing");
  excl_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
    !latch_on && sel_sig |=> !status[mie_pkg::S_ANYM])
    else $error("any-motion with significant selected");
  pin_or_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_ctrl[mie_pkg::OC_LVL] && !out_ctrl[mie_pkg::OC_OD] && |(status & map1) |=> int1_o)
    else $error("mapped flag not on pin one");
  loop_back_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_ctrl[mie_pkg::OC_OE] && latch_ctrl[mie_pkg::LT_IE] && out_ctrl[mie_pkg::OC_LVL] &&
    |(status & map1) |=> trig1)
    else $error("input path not fed from output");
  proof_hit_a: assert property (@(posedge clk) disable iff (!rst_b)
    sel_sig && sm_state == mie_pkg::SM_PROOF && sig_hit |=> sig_pulse &&
    sm_state == mie_pkg::SM_WAIT ##1 !sig_pulse)
    else $error("proof movement not reported");
  skip_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    sel_sig && sm_state == mie_pkg::SM_WAIT && sig_hit |=>
    sm_cnt == mie_pkg::skip_ticks($past(mot[3:2])))
    else $error("skip period wrong");
  step_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
    step_pulse |=> step_trig ##1 !step_trig || step_pulse)
    else $error("step not passed to counter");

  sig_found_c: cover property (@(posedge clk) disable iff (!rst_b) sig_pulse);
  loop_used_c: cover property (@(posedge clk) disable iff (!rst_b) trig1 && !int1_oe_b);
  susp_held_c: cover property (@(posedge clk) disable iff (!rst_b)
    latch_on && suspend && |status);
endmodule

// >>> tb/mie_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host side of the two pins
// ----------------------------------------
// a released pin not driven by the host floats to the pull-up, never to a stale level
module mie_host_model (
  input wire logic int1_o,
  input wire logic int1_oe_b,
  input wire logic int2_o,
  input wire logic int2_oe_b,
  input wire logic drv1,
  input wire logic drv1_val,
  output logic pin1,
  output logic pin2
);
  // host drives a pin only while the device has released it
  assign pin1 = !int1_oe_b ? int1_o : (drv1 ? drv1_val : 1'b1);
  assign pin2 = !int2_oe_b ? int2_o : 1'b1;
endmodule

// >>> tb/mie_top_tb.sv
`timescale 1ns/1ps
module mie_top_tb;
  logic clk, rst_b, reg_wr, suspend, smp_vld, drdy_evt, full_evt, wm_evt, drv1, drv1_val;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic signed [15:0] acc_x, acc_y, acc_z;
  logic [12:0] map1, map2, status;
  logic int1_o, int1_oe_b, int2_o, int2_oe_b, trig1, trig2, anym_sign, step_trig, pin1, pin2;
  logic [2:0] anym_axis;
  int n_errors = 0;
  int num_checks = 0;
  int n_steps = 0;
  // ----------------------------------------
  // design and host
  // ----------------------------------------
  // short tick keeps the skip and proof waits to a few hundred cycles
  mie_top #(.TICK_CYCLES(4)) i_mie_top (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .suspend(suspend),
    .smp_vld(smp_vld), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .drdy_evt(drdy_evt),
    .full_evt(full_evt), .wm_evt(wm_evt), .ext_evt(7'h00), .map1(map1), .map2(map2),
    .int1_i(pin1), .int1_o(int1_o), .int1_oe_b(int1_oe_b), .int2_i(pin2), .int2_o(int2_o),
    .int2_oe_b(int2_oe_b), .trig1(trig1), .trig2(trig2), .status(status),
    .anym_axis(anym_axis), .anym_sign(anym_sign), .step_trig(step_trig));
  mie_host_model i_mie_host_model (.int1_o(int1_o), .int1_oe_b(int1_oe_b), .int2_o(int2_o),
    .int2_oe_b(int2_oe_b), .drv1(drv1), .drv1_val(drv1_val), .pin1(pin1), .pin2(pin2));
  // step counter side: counts every pulse handed on
  always @(posedge clk) begin
    if (step_trig === 1'b1) begin
      n_steps++;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  // one sample; returns once its flag has had time to land
  task automatic smp(input logic signed [15:0] x, input logic signed [15:0] y,
                     input logic signed [15:0] z = 16'sh0000);
    @(posedge clk);
    acc_x <= x;
    acc_y <= y;
    acc_z <= z;
    smp_vld <= 1'b1;
    @(posedge clk);
    smp_vld <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // one-cycle pulse on {wm, full, drdy}; returns when the pin shows it
  task automatic ev(input logic [2:0] b);
    @(posedge clk);
    {wm_evt, full_evt, drdy_evt} <= b;
    @(posedge clk);
    {wm_evt, full_evt, drdy_evt} <= 3'b000;
    @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] ra [9] = '{8'h53, 8'h54, 8'h5F, 8'h60, 8'h61, 8'h62, 8'h7A, 8'h7B, 8'h55};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h24, 8'h14, 8'h14, 8'h00, 8'h00, 8'h00, 8'h00};
    chk("int1_oe_b", 16'h0001, {15'h0000, int1_oe_b});
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], rv[i]);
    end
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    wr(8'h60, 8'h10);
    rd(8'h60, 8'h10);
  endtask
  task automatic t_pins();
    @(posedge clk);
    map1 <= 13'h0400;
    map2 <= 13'h0800;
    wr(8'h53, 8'hAA);
    ev(3'b001);
    chk("int1_o", 16'h0001, {15'h0000, int1_o});
    chk("int1_oe_b", 16'h0000, {15'h0000, int1_oe_b});
    chk("int2_o", 16'h0000, {15'h0000, int2_o});
    ev(3'b010);
    chk("int2_o", 16'h0001, {15'h0000, int2_o});
    chk("int2_oe_b", 16'h0000, {15'h0000, int2_oe_b});
    chk("int1_o", 16'h0000, {15'h0000, int1_o});
    // active low with open drain: idle level is released to the pull-up
    wr(8'h53, 8'h0C);
    repeat (2) @(posedge clk);
    #1;
    chk("int1_oe_b", 16'h0001, {15'h0000, int1_oe_b});
    chk("pin1", 16'h0001, {15'h0000, pin1});
  endtask
  task automatic t_suspend();
    wr(8'h53, 8'h0A);
    suspend <= 1'b1;
    ev(3'b001);
    chk("int1_o", 16'h0000, {15'h0000, int1_o});
    @(posedge clk);
    suspend <= 1'b0;
    wr(8'h54, 8'h01);
    ev(3'b010);
    @(posedge clk);
    suspend <= 1'b1;
    ev(3'b100);
    chk("status", 16'h0800, {3'h0, status});
    rd(8'h54, 8'h41);
    wr(8'h54, 8'h81);
    rd(8'h54, 8'h01);
    chk("status", 16'h0000, {3'h0, status});
    @(posedge clk);
    suspend <= 1'b0;
  endtask
  task automatic t_trig();
    wr(8'h54, 8'h31);
    ev(3'b001);
    repeat (2) @(posedge clk);
    #1;
    chk("trig1", 16'h0001, {15'h0000, trig1});
    chk("trig2", 16'h0001, {15'h0000, trig2});
    // event and clear in one cycle: the event must survive
    @(posedge clk);
    drdy_evt <= 1'b1;
    wr(8'h54, 8'h90);
    drdy_evt <= 1'b0;
    #1;
    chk("status", 16'h0400, {3'h0, status});
    wr(8'h53, 8'h00);
    drv1 <= 1'b1;
    drv1_val <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("trig1", 16'h0001, {15'h0000, trig1});
    @(posedge clk);
    drv1_val <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("trig1", 16'h0000, {15'h0000, trig1});
    @(posedge clk);
    drv1 <= 1'b0;
    wr(8'h54, 8'h00);
  endtask
  task automatic t_anym();
    wr(8'h5F, 8'h00);
    smp(0, 0);
    smp(1000, 0);
    chk("status", 16'h0001, {3'h0, status});
    chk("anym_axis", 16'h0001, {13'h0000, anym_axis});
    smp(1000, 0);
    chk("status", 16'h0000, {3'h0, status});
    smp(1000, -1000);
    chk("anym_axis", 16'h0002, {13'h0000, anym_axis});
    chk("anym_sign", 16'h0001, {15'h0000, anym_sign});
    smp(1000, -1000);
    smp(1000, -1000, -2000);
    chk("anym_axis", 16'h0004, {13'h0000, anym_axis});
    smp(1000, -1000, -2000);
    wr(8'h54, 8'h01);
    smp(1000, 1000);
    smp(1000, 1000);
    smp(0, 1000);
    chk("anym_axis", 16'h0002, {13'h0000, anym_axis});
    smp(0, 1000);
    chk("status", 16'h0001, {3'h0, status});
    wr(8'h54, 8'h80);
    smp(32766, 1000);
    smp(32766, 1000);
    chk("status", 16'h0000, {3'h0, status});
    smp(32767, 1000);
    chk("status", 16'h0001, {3'h0, status});
  endtask
  task automatic t_sig();
    wr(8'h61, 8'h10);
    wr(8'h62, 8'h02);
    smp(0, 0);
    chk("status", 16'h0000, {3'h0, status});
    repeat (490) @(posedge clk);
    smp(1000, 0);
    chk("status", 16'h0000, {3'h0, status});
    repeat (40) @(posedge clk);
    smp(0, 0);
    chk("status", 16'h0002, {3'h0, status});
    wr(8'h62, 8'h00);
  endtask
  task automatic t_step();
    int n0;
    n0 = n_steps;
    smp(20000, 0);
    smp(0, 0);
    smp(20000, 0);
    smp(0, 0);
    repeat (20) @(posedge clk);
    smp(12000, 0);
    smp(0, 0);
    smp(20000, 0);
    smp(0, 0);
    chk("step_trig count", 16'h0002, 16'(n_steps - n0));
    wr(8'h7B, 8'h10);
    smp(12000, 0);
    smp(0, 0);
    chk("step_trig count", 16'h0003, 16'(n_steps - n0));
    wr(8'h7B, 8'h00);
  endtask
  // ----------------------------------------
  // clock, sequence, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst_b, reg_wr, suspend, smp_vld, drdy_evt, full_evt, wm_evt, drv1, drv1_val} = '0;
    {reg_addr, reg_wdata, acc_x, acc_y, acc_z, map1, map2} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    $display("registers done");
    t_pins();
    $display("pins done");
    t_suspend();
    $display("suspend done");
    t_trig();
    $display("input path done");
    t_anym();
    $display("any-motion done");
    t_sig();
    $display("significant motion done");
    t_step();
    $display("step detector done");
    report_and_stop();
  end
  // whole run is near 760 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule
